// ### logic/omc_pkg.sv
// package for the operation mode control register bank
// assumes a parallel byte-wide register port at the clk_i rate (250 MHz)
package omc_pkg;
   // register offsets (demultiplexed addressing)
   localparam logic [7:0] OMC_VERSION_OFS = 8'h0D;
   localparam logic [7:0] OMC_MODE_OFS = 8'h0F;
   localparam logic [7:0] OMC_MODE_RST = 8'h00;
   // mode selector encodings
   typedef enum logic [1:0] {
      OMC_MODE_CMRST = 2'h0,
      OMC_MODE_TEST = 2'h1,
      OMC_MODE_INIT = 2'h2,
      OMC_MODE_NORM = 2'h3
   } omc_mode_t;
   // memory command that resets the whole control memory (upper nibble)
   localparam logic [3:0] OMC_CMD_CMRST = 4'h7;
   localparam logic [3:0] OMC_CODE_UNASSIGNED = 4'h0;
   // access cost in reference clock cycles; halves are counted in half cycles
   localparam int OMC_RST_CYC = 256;
   localparam int OMC_INIT_HALF = 5;
   localparam int OMC_NORM_HALF = 19;
   localparam int OMC_TRI_CYC = 1035;
   localparam int OMC_TEST_CYC = 2057;
   // field positions in the mode register
   localparam int OMC_B_HWOE = 5;
   localparam int OMC_B_LOOP = 4;
   localparam int OMC_B_ODRN = 3;
   localparam int OMC_B_MHS = 2;
   localparam int OMC_B_SOE = 1;
   localparam int OMC_B_BANK = 0;
   localparam int OMC_TIMER_W = 12;
   typedef struct packed {
      logic [1:0] op_mode_select;
      logic highway_output_enable;
      logic highway_loopback;
      logic subscriber_open_drain;
      logic monitor_handshake_enable;
      logic subscriber_output_enable;
      logic register_bank_select;
   } omc_mode_reg_t;
endpackage

// ### logic/omc_sync.sv
// three-stage synchroniser with agreement filter
// assumes an asynchronous level input
module omc_sync
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } omc_sync_st_t;
   omc_sync_st_t st_r;
   omc_sync_st_t st_nxt;
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = d_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // change counts once stages two and three agree
      if (st_r.s2 == st_r.s3)
      begin
         st_nxt.q = st_r.s3;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign q_o = st_r.q;
endmodule

// ### logic/omc_top.sv
// operation mode control: mode register, version/status register, access timing
// assumes a synchronous host port on clk_i and reference clock cycles = clk_i cycles
// How it works
// R1: selector 00 memory reset, 10 fast init, 11 normal, 01 test.
// R2: reset-mode command clears whole control memory within 256 cycles.
// R3: reset mode stops normal running; both interfaces not operational.
// R4: command 70h fills data fields with data register, codes with 0000.
// R5: host should do a full memory reset after every hardware reset.
// R6: fast init: single addressed access, at most 2.5 cycles (rounded up to 3 here), no normal run.
// R7: normal mode: interfaces run; single access takes 9.5 cycles (rounded up to 10 here).
// R8: normal mode: full tristate field initialisation takes 1035 cycles.
// R9: test mode: runs normally, access covers all locations, 2057 cycles.
// R10: highway enable 0 floats transmit, tristate control 1; else data.
// R11: loopback routes transmit data to receive, external receive ignored.
// R12: subscriber driver bit: 0 tristate drivers, 1 open drain.
// R13: monitor handshake bit: 0 disabled, 1 enabled.
// R14: subscriber enable 0 floats four outputs; 1 drives them.
// R15: bank select maps operational set 0, initialisation set 1.
// R16: init request sets on bad clock or power fail, clears on memory reset.
// R17: four version bits read only, fixed revision code.
// R18: host programs alternate input select and compare to 00.
// R19: host programs subscriber port select fields to 00.
// R20: host sets highway input mismatch mask bit to 1.
// R21: new mode and control settings apply right after the write.
module omc_top
#(
   parameter logic [3:0] VERSION_NUMBER = 4'h5 // arbitrary value
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic demux_mode_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // memory command from the access unit
   input wire logic mem_cmd_i,
   input wire logic [7:0] mem_cmd_val_i,
   input wire logic [7:0] mem_data_i,
   input wire logic mem_tri_init_i,
   output logic mem_busy_o,
   output logic mem_done_o,
   output logic mem_all_loc_o,
   output logic mem_wr_code_o,
   output logic [3:0] mem_code_o,
   output logic [7:0] mem_fill_data_o,
   // clock supervisor
   input wire logic clock_fault_i,
   // highway pins
   input wire logic highway_tx_data_i,
   input wire logic highway_tri_field_i,
   input wire logic highway_rx_pin_i,
   output logic highway_tx_o,
   output logic highway_tx_oe_o,
   output logic tristate_control_out_o,
   output logic highway_rx_o,
   // subscriber pins
   input wire logic [3:0] subscriber_data_i,
   output logic [3:0] subscriber_pin_o,
   output logic [3:0] subscriber_pin_oe_o,
   // mode status
   output logic normal_run_o,
   output logic monitor_handshake_enable_o,
   output logic register_bank_o
);
   localparam int OMC_CW = 13;
   typedef enum logic [1:0] {
      OMC_IDLE = 2'h0,
      OMC_RUN = 2'h1,
      OMC_DONE = 2'h3
   } omc_state_t;
   typedef struct packed {
      omc_pkg::omc_mode_reg_t mode;
      logic init_request;
      omc_state_t fsm;
      logic [OMC_CW-1:0] cnt;
      logic is_rst;
      logic [7:0] rdata;
      logic rvalid;
      logic busy;
      logic done;
      logic all_loc;
      logic wr_code;
      logic [7:0] fill;
      logic tx;
      logic tx_oe;
      logic tri_ctl;
      logic rx;
      logic [3:0] sub;
      logic [3:0] sub_oe;
      logic run;
   } omc_st_t;
   omc_st_t st_r;
   omc_st_t st_nxt;
   logic rx_sync;
   logic fault_sync;
   omc_sync u_rx_sync
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(highway_rx_pin_i),
      .q_o(rx_sync)
   );
   omc_sync u_fault_sync
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(clock_fault_i),
      .q_o(fault_sync)
   );
   // cost of one access in reference cycles, fractions rounded up
   function automatic logic [OMC_CW-1:0] access_cycles(input logic [1:0] m, input logic tri_i);
      logic [OMC_CW-1:0] c;
      c = OMC_CW'(omc_pkg::OMC_RST_CYC);
      case (m) // R1
         omc_pkg::OMC_MODE_INIT: c = OMC_CW'((omc_pkg::OMC_INIT_HALF + 1) / 2);
         omc_pkg::OMC_MODE_NORM:
            c = tri_i ? OMC_CW'(omc_pkg::OMC_TRI_CYC)
                      : OMC_CW'((omc_pkg::OMC_NORM_HALF + 1) / 2);
         omc_pkg::OMC_MODE_TEST: c = OMC_CW'(omc_pkg::OMC_TEST_CYC);
         default: c = OMC_CW'(omc_pkg::OMC_RST_CYC);
      endcase
      return c;
   endfunction
   logic is_mode_wr;
   logic is_rst_cmd;
   logic interfaces_up;
   assign is_mode_wr = reg_wr_i && (reg_addr_i == omc_pkg::OMC_MODE_OFS);
   assign is_rst_cmd = (st_r.mode.op_mode_select == omc_pkg::OMC_MODE_CMRST)
                       && (mem_cmd_val_i[7:4] == omc_pkg::OMC_CMD_CMRST);
   // R3 R7 R9: interfaces run in normal and test modes only
   assign interfaces_up = st_r.mode.op_mode_select[0];
   // selector reaches the pins one edge after the enables, off the write path
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      st_nxt.rvalid = 1'b0;
      // register write takes effect on the next edge
      if (is_mode_wr)
      begin
         st_nxt.mode = omc_pkg::omc_mode_reg_t'(reg_wdata_i); // R21
      end
      // register read
      if (reg_rd_i)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = 8'h00;
         if (reg_addr_i == omc_pkg::OMC_MODE_OFS)
         begin
            st_nxt.rdata = st_r.mode;
         end
         else if ((reg_addr_i == omc_pkg::OMC_VERSION_OFS)
                  && (st_r.mode.register_bank_select || !demux_mode_i)) // R15
         begin
            st_nxt.rdata = {st_r.init_request, 3'h0, VERSION_NUMBER}; // R17
         end
      end
      // memory access sequencer
      // a command seen while busy is dropped, not queued
      case (st_r.fsm)
         OMC_IDLE:
         begin
            if (mem_cmd_i)
            begin
               st_nxt.fsm = OMC_RUN;
               st_nxt.busy = 1'b1;
               st_nxt.cnt = access_cycles(st_r.mode.op_mode_select, mem_tri_init_i) - 1'b1; // R2 R6 R7 R8 R9
               st_nxt.is_rst = is_rst_cmd;
               // R9: test and reset modes ignore the address register
               st_nxt.all_loc = !st_r.mode.op_mode_select[1];
               st_nxt.wr_code = is_rst_cmd; // R4
               st_nxt.fill = mem_data_i; // R4
            end
         end
         OMC_RUN:
         begin
            if (st_r.cnt == '0)
            begin
               st_nxt.fsm = OMC_DONE;
            end
            else
            begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end
         OMC_DONE:
         begin
            st_nxt.fsm = OMC_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
            st_nxt.all_loc = 1'b0;
            st_nxt.wr_code = 1'b0;
            if (st_r.is_rst)
            begin
               st_nxt.init_request = 1'b0; // R16
            end
         end
         default: st_nxt.fsm = OMC_IDLE;
      endcase
      // a fault in the same cycle wins over the clear
      if (fault_sync)
      begin
         st_nxt.init_request = 1'b1; // R16
      end
      // highway pins follow the mode register from the next edge on
      st_nxt.run = interfaces_up; // R3 R6
      st_nxt.tx = highway_tx_data_i;
      st_nxt.tx_oe = interfaces_up && st_nxt.mode.highway_output_enable
                     && !highway_tri_field_i; // R10 R11
      st_nxt.tri_ctl = !st_nxt.tx_oe; // R10
      st_nxt.rx = st_nxt.mode.highway_loopback ? highway_tx_data_i : rx_sync; // R11
      // subscriber pins: open drain drives only low
      st_nxt.sub = subscriber_data_i;
      for (int i = 0; i < 4; i++)
      begin
         if (st_nxt.mode.subscriber_open_drain)
         begin
            st_nxt.sub[i] = 1'b0; // R12
            st_nxt.sub_oe[i] = interfaces_up && st_nxt.mode.subscriber_output_enable
                               && !subscriber_data_i[i];
         end
         else
         begin
            st_nxt.sub_oe[i] = interfaces_up && st_nxt.mode.subscriber_output_enable; // R14
         end
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r <= '0;
         st_r.mode <= omc_pkg::omc_mode_reg_t'(omc_pkg::OMC_MODE_RST);
         st_r.init_request <= 1'b1;
         st_r.fsm <= OMC_IDLE;
         st_r.tri_ctl <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign reg_rdata_o = st_r.rdata;
   assign reg_rvalid_o = st_r.rvalid;
   assign mem_busy_o = st_r.busy;
   assign mem_done_o = st_r.done;
   assign mem_all_loc_o = st_r.all_loc;
   assign mem_wr_code_o = st_r.wr_code;
   assign mem_code_o = omc_pkg::OMC_CODE_UNASSIGNED;
   assign mem_fill_data_o = st_r.fill;
   assign highway_tx_o = st_r.tx;
   assign highway_tx_oe_o = st_r.tx_oe;
   assign tristate_control_out_o = st_r.tri_ctl;
   assign highway_rx_o = st_r.rx;
   assign subscriber_pin_o = st_r.sub;
   assign subscriber_pin_oe_o = st_r.sub_oe;
   assign normal_run_o = st_r.run;
   assign monitor_handshake_enable_o = st_r.mode.monitor_handshake_enable; // R13
   assign register_bank_o = st_r.mode.register_bank_select;
   // assertions; antecedents on mode fields other than the selector use the next mode, since a write lands on the same edge, save a_ver_fixed's past bank select
   a_mode_applied: assert property (@(posedge clk_i) disable iff (rst_i) // R21
      is_mode_wr |=> st_r.mode == $past(reg_wdata_i))
      else $error("mode write not applied");
   a_hw_float: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      !st_nxt.mode.highway_output_enable |=> !highway_tx_oe_o && tristate_control_out_o)
      else $error("highway driven while on standby");
   a_tri_pair: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      tristate_control_out_o != highway_tx_oe_o)
      else $error("tristate control disagrees with highway enable");
   a_sub_float: assert property (@(posedge clk_i) disable iff (rst_i) // R14
      !st_nxt.mode.subscriber_output_enable |=> subscriber_pin_oe_o == 4'h0)
      else $error("subscriber pins driven while on standby");
   a_drain_low: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      st_nxt.mode.subscriber_open_drain |=> subscriber_pin_o == 4'h0)
      else $error("open drain pin driven high");
   a_rst_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      st_r.mode.op_mode_select == 2'h0 |=> !normal_run_o && !highway_tx_oe_o)
      else $error("interfaces running in reset mode");
   a_init_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      st_r.mode.op_mode_select == 2'h2 |=> !normal_run_o)
      else $error("normal running in fast init mode");
   a_norm_run: assert property (@(posedge clk_i) disable iff (rst_i) // R7
      st_r.mode.op_mode_select == 2'h3 |=> normal_run_o)
      else $error("normal mode not running");
   a_loop_rx: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      st_nxt.mode.highway_loopback |=> highway_rx_o == $past(highway_tx_data_i))
      else $error("loopback data mismatch");
   a_hs_follow: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      is_mode_wr |=> monitor_handshake_enable_o == $past(reg_wdata_i[omc_pkg::OMC_B_MHS]))
      else $error("handshake enable not applied");
   a_bank_follow: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      is_mode_wr |=> register_bank_o == $past(reg_wdata_i[omc_pkg::OMC_B_BANK]))
      else $error("bank select not applied");
   sequence s_cmd_taken;
      st_r.fsm == OMC_IDLE && mem_cmd_i;
   endsequence
   sequence s_rst_start;
      st_r.fsm == OMC_IDLE && mem_cmd_i && st_r.mode.op_mode_select == 2'h0;
   endsequence
   a_rst_time: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      s_rst_start |-> ##[1:258] mem_done_o)
      else $error("memory reset too slow");
   a_init_time: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      st_r.fsm == OMC_IDLE && mem_cmd_i && st_r.mode.op_mode_select == 2'h2
      |-> ##[1:5] mem_done_o)
      else $error("init access too slow");
   a_norm_time: assert property (@(posedge clk_i) disable iff (rst_i) // R7
      s_cmd_taken ##0 (st_r.mode.op_mode_select == 2'h3 && !mem_tri_init_i)
      |-> ##12 mem_done_o)
      else $error("normal access time wrong");
   a_test_span: assert property (@(posedge clk_i) disable iff (rst_i) // R9
      s_cmd_taken ##0 (st_r.mode.op_mode_select == 2'h1) |=> mem_all_loc_o && mem_busy_o)
      else $error("test access not over all locations");
   a_busy_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      st_r.fsm == OMC_RUN |=> mem_busy_o)
      else $error("busy dropped before done");
   a_done_drop: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      mem_done_o |-> !mem_busy_o && !mem_all_loc_o && !mem_wr_code_o)
      else $error("access still busy at done");
   a_code_fill: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      st_r.fsm == OMC_IDLE && mem_cmd_i && is_rst_cmd |=> mem_wr_code_o && mem_all_loc_o)
      else $error("reset fill not started");
   a_ver_fixed: assert property (@(posedge clk_i) disable iff (rst_i) // R17
      reg_rvalid_o && $past(reg_addr_i) == 8'h0D && $past(st_r.mode.register_bank_select)
      |-> reg_rdata_o[6:0] == {3'h0, VERSION_NUMBER})
      else $error("version bits wrong");
   a_ir_set: assert property (@(posedge clk_i) disable iff (rst_i) // R16
      fault_sync |=> st_r.init_request)
      else $error("init request not set");
   sequence s_rst_done;
      st_r.fsm == OMC_DONE && st_r.is_rst && !fault_sync;
   endsequence
   a_ir_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R16
      s_rst_done |=> !st_r.init_request)
      else $error("init request not cleared");
endmodule

// ### testbench/omc_host_model.sv
// host model: byte-wide register master of the mode control bank
// assumes one access at a time, strobe taken at the clock edge that sees it
module omc_host_model
(
   // clock
   input wire logic clk_i,
   // register port
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // alternate-input, port-select and mismatch-mask values are not written here
   // the bank holds none of those registers
   initial
   begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // released lines flip so a stale value never passes for a held one
   task automatic idle();
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~reg_addr_o;
      reg_wdata_o <= ~reg_wdata_o;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= v;
      @(posedge clk_i);
      idle();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
      int k;
      @(posedge clk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge clk_i);
      idle();
      ok = 1'b0;
      v = 8'h00;
      for (k = 0; k < 3 && !ok; k++)
      begin
         #1;
         if (reg_rvalid_i === 1'b1)
         begin
            v = reg_rdata_i;
            ok = 1'b1;
         end
         else
         begin
            @(posedge clk_i);
         end
      end
   endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench of the operation mode control bank
// assumes the host model owns the register port; the bench drives the rest
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] mr = omc_pkg::OMC_MODE_OFS;
   localparam logic [7:0] vr = omc_pkg::OMC_VERSION_OFS;
   localparam logic [3:0] ver = 4'h9; // arbitrary value
   logic clk_i, rst_i, demux, cmd, tri_i, fault, hw_txd, hw_tri, hw_rxp;
   logic [7:0] cmd_v, mdata, rdata, wdata, addr, d;
   logic [3:0] sub_d, sub_p, sub_oe, mcode;
   logic wr, rd, rvalid, busy, done, all_loc, wr_code, tx, tx_oe, tctl, rx_o;
   logic run, mhs, bank, ok;
   logic [1:0] s;
   logic [7:0] fill;
   int err_count = 0;
   int n_checks = 0;
   int i;
   omc_top #(.VERSION_NUMBER(ver)) omc_top_i (.clk_i(clk_i), .rst_i(rst_i),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .demux_mode_i(demux), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .mem_cmd_i(cmd), .mem_cmd_val_i(cmd_v), .mem_data_i(mdata), .mem_tri_init_i(tri_i),
      .mem_busy_o(busy), .mem_done_o(done), .mem_all_loc_o(all_loc),
      .mem_wr_code_o(wr_code), .mem_code_o(mcode), .mem_fill_data_o(fill),
      .clock_fault_i(fault), .highway_tx_data_i(hw_txd), .highway_tri_field_i(hw_tri),
      .highway_rx_pin_i(hw_rxp), .highway_tx_o(tx), .highway_tx_oe_o(tx_oe),
      .tristate_control_out_o(tctl), .highway_rx_o(rx_o), .subscriber_data_i(sub_d),
      .subscriber_pin_o(sub_p), .subscriber_pin_oe_o(sub_oe), .normal_run_o(run),
      .monitor_handshake_enable_o(mhs), .register_bank_o(bank));
   omc_host_model omc_host_model_i (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && n_checks > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      omc_host_model_i.rd(a, d, ok);
      chk({7'h00, ok, d}, {8'h01, e});
   endtask
   // settings are looked at one edge after the write is taken
   task automatic wrm(input logic [7:0] v);
      omc_host_model_i.wr(mr, v);
      @(posedge clk_i);
      #1;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic mem_op(input logic [7:0] v, input logic t, input int n, input logic al,
      input logic wc);
      int k;
      logic ax;
      ax = (al === 1'bx);
      @(posedge clk_i);
      cmd <= 1'b1;
      cmd_v <= v;
      tri_i <= t;
      @(posedge clk_i);
      cmd <= 1'b0;
      for (k = 1; k < 3000; k++)
      begin
         @(posedge clk_i);
         #1;
         if (k == 1)
         begin
            chk({busy, all_loc | ax, wr_code}, {1'b1, al | ax, wc});
            if (wc)
            begin
               chk({mcode, fill}, {omc_pkg::OMC_CODE_UNASSIGNED, mdata});
            end
         end
         if (done === 1'b1)
         begin
            break;
         end
      end
      chk({busy, 15'(k)}, {1'b0, 15'(n + 1)});
   endtask
   initial
   begin
      #100000;
      err_count++;
      report_and_stop();
   end
   initial
   begin
      rst_i = 1'b1;
      {demux, cmd, tri_i, fault, hw_txd, hw_tri, hw_rxp} = 7'h40;
      cmd_v = 8'h00;
      mdata = 8'h3C;
      sub_d = 4'hA;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk({tx_oe, tctl, sub_oe, run}, {1'b0, 1'b1, 4'h0, 1'b0});
      rdc(mr, omc_pkg::OMC_MODE_RST);
      rdc(vr, 8'h00);
      wrm(8'h01);
      chk(bank, 1'b1);
      rdc(vr, {4'h8, ver});
      omc_host_model_i.wr(vr, 8'h7F);
      rdc(vr, {4'h8, ver});
      rdc(8'h33, 8'h00);
      mem_op(8'h70, 1'b0, omc_pkg::OMC_RST_CYC, 1'b1, 1'b1);
      rdc(vr, {4'h0, ver});
      @(posedge clk_i);
      fault <= 1'b1;
      tick(8);
      @(posedge clk_i);
      fault <= 1'b0;
      wrm(8'h00);
      @(posedge clk_i);
      demux <= 1'b0;
      rdc(vr, {4'h8, ver});
      @(posedge clk_i);
      demux <= 1'b1;
      for (i = 0; i < 4; i++)
      begin
         wrm({i[1:0], 6'h02});
         chk({run, sub_oe}, {i[0], {4{i[0]}}});
      end
      wrm(8'h80);
      mem_op(8'h10, 1'b0, (omc_pkg::OMC_INIT_HALF + 1) / 2, 1'b0, 1'b0);
      wrm(8'hC0);
      mem_op(8'h10, 1'b0, (omc_pkg::OMC_NORM_HALF + 1) / 2, 1'b0, 1'b0);
      mem_op(8'h10, 1'b1, omc_pkg::OMC_TRI_CYC, 1'bx, 1'b0);
      wrm(8'h40);
      mem_op(8'h10, 1'b0, omc_pkg::OMC_TEST_CYC, 1'b1, 1'b0);
      wrm(8'hC2);
      chk({tx_oe, tctl, sub_oe, sub_p}, {2'h1, 4'hF, 4'hA});
      wrm(8'hCA);
      chk({sub_oe, sub_p}, {~sub_d, 4'h0});
      wrm(8'hE4);
      chk({mhs, bank}, 2'h2);
      for (i = 0; i < 2; i++)
      begin
         @(posedge clk_i);
         hw_tri <= i[0];
         hw_txd <= 1'b1;
         tick(2);
         s[i] = tx_oe;
         chk({tx, tx_oe, tctl}, {1'b1, ~i[0], i[0]});
      end
      chk(s[0] ^ s[1], 1'b1);
      wrm(8'hF0);
      @(posedge clk_i);
      hw_rxp <= 1'b0;
      tick(6);
      chk(rx_o, 1'b1);
      @(posedge clk_i);
      hw_txd <= 1'b0;
      hw_rxp <= 1'b1;
      tick(6);
      chk(rx_o, 1'b0);
      wrm(8'hE0);
      tick(6);
      chk(rx_o, 1'b1);
      report_and_stop();
   end
endmodule
